// *** tss_defines.svh ***
// Purpose: offsets, field positions, reset values for trigger select
// Assumes: 32-bit Avalon-MM word addressing in bytes
// Notes:   definitions only
`ifndef TSS_DEFINES_SVH
`define TSS_DEFINES_SVH
`define TSS_OFF_CTRL      8'h00
`define TSS_OFF_CNT_CFG   8'h04
`define TSS_OFF_CNT_PRE   8'h08
`define TSS_OFF_CNT_CUR   8'h0C
`define TSS_OFF_CMD       8'h10
`define TSS_OFF_STAT      8'h14
`define TSS_CTRL_MODE     0
`define TSS_CTRL_SRC_LO   4
`define TSS_CTRL_SRC_HI   6
`define TSS_CTRL_L2DIR    8
`define TSS_CTRL_L1OUT    9
`define TSS_CTRL_L2OUT    10
`define TSS_CFG_SEL       0
`define TSS_CFG_EVT_LO    4
`define TSS_CFG_EVT_HI    5
`define TSS_CFG_RST       8
`define TSS_CMD_SWTRIG    0
`define TSS_CMD_CNTRST    1
`define TSS_CMD_ACTION    2
`define TSS_PRE_RESET     10'h001
`define TSS_PRE_MIN       10'h001
`define TSS_PRE_MAX       10'h3FF
`endif

// *** tss_pkg.sv ***
// Purpose: types for trigger source select
// Assumes: used with tss_defines.svh
// Notes:   encodings follow selector order
package tss_pkg;
  typedef enum logic [2:0] {
    TSS_SRC_SOFTWARE = 3'h0,
    TSS_SRC_LINE0    = 3'h1,
    TSS_SRC_LINE2    = 3'h2,
    TSS_SRC_COUNTER0 = 3'h3,
    TSS_SRC_ACTION1  = 3'h4,
    TSS_SRC_ANYWAY   = 3'h5
  } tss_src_t;
  typedef enum logic [1:0] {
    TSS_EVT_OFF   = 2'h0,
    TSS_EVT_LINE0 = 2'h1,
    TSS_EVT_LINE2 = 2'h2
  } tss_evt_t;
endpackage

// *** tss_top.sv ***
// Purpose: acquisition trigger source selection with event counter
// Assumes: line inputs asynchronous; rising edge is the active edge
// Notes:   one-cycle acquisition start pulse on acq_start_o
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tss_defines.svh"

// Overview of operation
// - mode off: acquisitions start from internal timer pulses.
// - mode on: acquisitions start only from the selected external source.
// - external sources are ignored while mode is off.
// - with software or anyway source, each software trigger command starts one acquisition.
// - hardware source takes edges from line 0 or line 2.
// - line 2 direction is set by a software direction bit.
// - line 1 is always driven as a dedicated output.
// - counter source starts acquisitions from counter pulses.
// - action source starts acquisitions from received action commands.
// - anyway source accepts software and hardware line triggers.
// - counter selector is read-write and holds only counter 0.
// - event source read-write, line0 or line2, resets to disabled.
// - reset source read-write, software only, resets to disabled.
// - counter reset command acts only with software reset source.
// - preset value is read-write, limited to 1 through 1023.
// - current value is read-only, counts executed external triggers.
module tss_top
  import tss_pkg::*;
#(
  parameter int INT_PERIOD = 1000000
)(
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        line0_i,
  input  wire logic        line2_i,
  output logic             line2_o,
  output logic             line2_oe_o,
  output logic             line1_o,
  input  wire logic        action_i,
  output logic             acq_start_o
);
  initial begin
    if (INT_PERIOD < 2) $error("INT_PERIOD must be at least 2");
  end

  logic        mode_q;
  tss_src_t    src_q;
  logic        l2dir_q;
  logic        l1val_q;
  logic        l2val_q;
  logic        csel_q;
  tss_evt_t    evt_q;
  logic        rsrc_q;
  logic [9:0]  pre_q;
  logic [9:0]  cnt_q;
  logic [31:0] ext_q;
  logic        cpulse_q;
  logic [31:0] tmr_q;
  logic        tpulse_q;
  logic        ack_q;
  logic        swtrig_q;
  logic        cntrst_q;
  logic        actcmd_q;
  logic [2:0]  l0_s_q;
  logic [2:0]  l2_s_q;
  logic [2:0]  ac_s_q;
  logic        l0_rise;
  logic        l2_rise;
  logic        ac_rise;
  logic        evt_hit;
  logic        ext_trig;
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  byte_addr;
  logic [31:0] rd_d;
  logic [9:0]  pre_wr;

  assign byte_addr = {1'b0, avs_address_i, 2'b00};
  // writes land when waitrequest is low; reads capture a cycle earlier
  assign wr_acc = avs_write_i && ack_q;
  assign rd_acc = avs_read_i && !ack_q;

  // two-stage synchronisers; bit 2 is the edge history only
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      l0_s_q <= 3'h0;
      l2_s_q <= 3'h0;
      ac_s_q <= 3'h0;
    end else begin
      l0_s_q <= {l0_s_q[1:0], line0_i};
      l2_s_q <= {l2_s_q[1:0], line2_i};
      ac_s_q <= {ac_s_q[1:0], action_i};
    end
  end
  assign l0_rise = l0_s_q[1] && !l0_s_q[2];
  // line 2 counts only while configured as input
  assign l2_rise = l2_s_q[1] && !l2_s_q[2] && !l2dir_q;
  assign ac_rise = ac_s_q[1] && !ac_s_q[2];

  // bus handshake
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end
  assign avs_waitrequest_o = !ack_q;

  // control register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q  <= 1'b0;
      src_q   <= TSS_SRC_SOFTWARE;
      l2dir_q <= 1'b0;
      l1val_q <= 1'b0;
      l2val_q <= 1'b0;
    end else if (wr_acc && byte_addr == `TSS_OFF_CTRL
                 && avs_byteenable_i[0] && avs_byteenable_i[1]) begin
      mode_q <= avs_writedata_i[`TSS_CTRL_MODE];
      // unlisted codes are refused, selector keeps value
      if (avs_writedata_i[`TSS_CTRL_SRC_HI:`TSS_CTRL_SRC_LO] <= 3'h5) begin
        src_q <= tss_src_t'(
          avs_writedata_i[`TSS_CTRL_SRC_HI:`TSS_CTRL_SRC_LO]);
      end
      l2dir_q <= avs_writedata_i[`TSS_CTRL_L2DIR];
      l1val_q <= avs_writedata_i[`TSS_CTRL_L1OUT];
      l2val_q <= avs_writedata_i[`TSS_CTRL_L2OUT];
    end
  end

  // counter configuration
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csel_q <= 1'b0;
      evt_q  <= TSS_EVT_OFF;
      rsrc_q <= 1'b0;
    end else if (wr_acc && byte_addr == `TSS_OFF_CNT_CFG
                 && avs_byteenable_i[0] && avs_byteenable_i[1]) begin
      csel_q <= 1'b0; // only counter 0 exists
      if (avs_writedata_i[`TSS_CFG_EVT_HI:`TSS_CFG_EVT_LO] != 2'h3) begin
        evt_q <= tss_evt_t'(
          avs_writedata_i[`TSS_CFG_EVT_HI:`TSS_CFG_EVT_LO]);
      end
      rsrc_q <= avs_writedata_i[`TSS_CFG_RST];
    end
  end

  // preset, out-of-range writes dropped rather than clamped
  assign pre_wr = avs_writedata_i[9:0];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_q <= `TSS_PRE_RESET;
    end else if (wr_acc && byte_addr == `TSS_OFF_CNT_PRE
                 && avs_byteenable_i[0] && avs_byteenable_i[1]
                 && avs_writedata_i[31:10] == 22'h0
                 && pre_wr >= `TSS_PRE_MIN) begin
      pre_q <= pre_wr;
    end
  end

  // command strobes, one cycle each
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      swtrig_q <= 1'b0;
      cntrst_q <= 1'b0;
      actcmd_q <= 1'b0;
    end else begin
      swtrig_q <= wr_acc && byte_addr == `TSS_OFF_CMD
                  && avs_byteenable_i[0]
                  && avs_writedata_i[`TSS_CMD_SWTRIG];
      cntrst_q <= wr_acc && byte_addr == `TSS_OFF_CMD
                  && avs_byteenable_i[0] && rsrc_q
                  && avs_writedata_i[`TSS_CMD_CNTRST];
      actcmd_q <= (wr_acc && byte_addr == `TSS_OFF_CMD
                   && avs_byteenable_i[0]
                   && avs_writedata_i[`TSS_CMD_ACTION]) || ac_rise;
    end
  end

  // event counter
  always_comb begin
    case (evt_q)
      TSS_EVT_LINE0: evt_hit = l0_rise;
      TSS_EVT_LINE2: evt_hit = l2_rise;
      default:       evt_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q    <= 10'h000;
      cpulse_q <= 1'b0;
    end else begin
      cpulse_q <= 1'b0;
      if (cntrst_q) begin
        cnt_q <= 10'h000; // no pulse on reset
      end else if (evt_hit) begin
        if (cnt_q + 10'h001 >= pre_q) begin
          cnt_q    <= 10'h000;
          cpulse_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end

  // internal timer for internal trigger mode
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_q    <= 32'h0;
      tpulse_q <= 1'b0;
    end else begin
      tpulse_q <= 1'b0;
      if (tmr_q >= 32'(INT_PERIOD - 1)) begin
        tmr_q    <= 32'h0;
        tpulse_q <= 1'b1;
      end else begin
        tmr_q <= tmr_q + 32'h1;
      end
    end
  end

  // source selection
  always_comb begin
    case (src_q)
      TSS_SRC_SOFTWARE: ext_trig = swtrig_q;
      TSS_SRC_LINE0:    ext_trig = l0_rise;
      TSS_SRC_LINE2:    ext_trig = l2_rise;
      TSS_SRC_COUNTER0: ext_trig = cpulse_q;
      TSS_SRC_ACTION1:  ext_trig = actcmd_q;
      TSS_SRC_ANYWAY:   ext_trig = swtrig_q || l0_rise || l2_rise;
      default:          ext_trig = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acq_start_o <= 1'b0;
    end else begin
      // external only in mode on, internal only in mode off
      acq_start_o <= mode_q ? ext_trig : tpulse_q;
    end
  end

  // executed external triggers, read only
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_q <= 32'h0;
    end else if (mode_q && ext_trig) begin
      ext_q <= ext_q + 32'h1;
    end
  end

  // output lines
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line1_o    <= 1'b0;
      line2_o    <= 1'b0;
      line2_oe_o <= 1'b0;
    end else begin
      line1_o    <= l1val_q;
      line2_o    <= l2val_q;
      line2_oe_o <= l2dir_q;
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_d = 32'h0;
    case (byte_addr)
      `TSS_OFF_CTRL: begin
        rd_d[`TSS_CTRL_MODE] = mode_q;
        rd_d[`TSS_CTRL_SRC_HI:`TSS_CTRL_SRC_LO] = src_q;
        rd_d[`TSS_CTRL_L2DIR] = l2dir_q;
        rd_d[`TSS_CTRL_L1OUT] = l1val_q;
        rd_d[`TSS_CTRL_L2OUT] = l2val_q;
      end
      `TSS_OFF_CNT_CFG: begin
        rd_d[`TSS_CFG_SEL] = csel_q;
        rd_d[`TSS_CFG_EVT_HI:`TSS_CFG_EVT_LO] = evt_q;
        rd_d[`TSS_CFG_RST] = rsrc_q;
      end
      `TSS_OFF_CNT_PRE: rd_d[9:0] = pre_q;
      `TSS_OFF_CNT_CUR: rd_d = ext_q;
      `TSS_OFF_STAT:    rd_d[9:0] = cnt_q;
      default:          rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (rd_acc) begin
      avs_readdata_o <= rd_d;
    end
  end

  // assertions
  mode_off_ext_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !mode_q |=> (acq_start_o == $past(tpulse_q)))
    else $error("internal mode start mismatch");
  mode_on_ext_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    mode_q |=> (acq_start_o == $past(ext_trig)))
    else $error("external mode start mismatch");
  ignore_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!mode_q && !tpulse_q) |=> !acq_start_o)
    else $error("start while mode off");
  src_legal_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    src_q <= TSS_SRC_ANYWAY)
    else $error("illegal source");
  sw_one_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (mode_q && src_q == TSS_SRC_SOFTWARE && swtrig_q) |=> acq_start_o)
    else $error("software trigger lost");
  preset_range_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pre_q >= `TSS_PRE_MIN)
    else $error("preset out of range");
  rst_gate_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cntrst_q |-> $past(rsrc_q))
    else $error("counter reset without software source");
  sequence s_reset_cmd;
    cntrst_q;
  endsequence
  sequence s_cleared;
    cnt_q == 10'h000 && !cpulse_q;
  endsequence
  cnt_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_reset_cmd |=> s_cleared)
    else $error("counter reset failed");
  cnt_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (evt_hit && !cntrst_q && cnt_q + 10'h001 >= pre_q)
    |=> (cpulse_q && cnt_q == 10'h000))
    else $error("counter wrap failed");
  l1_drive_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ##1 line1_o == $past(l1val_q))
    else $error("line1 not driven");
  l2_dir_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ##1 line2_oe_o == $past(l2dir_q))
    else $error("line2 direction wrong");
endmodule
`default_nettype wire

// *** tss_trig_src_model.sv ***
// Purpose: external trigger devices on lines 0 and 2 and action input
// Assumes: one clock; levels change just after a rising edge
// Notes:   line 2 level resolved from device and far driver
`timescale 1ns/10ps
`default_nettype none
module tss_trig_src_model (
  input  wire logic clk_sys_i,
  input  wire logic line2_o,
  input  wire logic line2_oe_o,
  output logic      line0_o,
  output logic      line2_i_o,
  output logic      action_o
);
  logic far2_q;
  // device wins while it drives line 2
  assign line2_i_o = line2_oe_o ? line2_o : far2_q;
  initial begin
    line0_o = 1'b0;
    far2_q = 1'b0;
    action_o = 1'b0;
  end
  // gap after release lets the synchroniser see the low level
  task automatic pulse(input int sel, input int width);
    @(posedge clk_sys_i);
    case (sel)
      0: line0_o <= 1'b1;
      1: far2_q <= 1'b1;
      default: action_o <= 1'b1;
    endcase
    repeat (width) @(posedge clk_sys_i);
    line0_o <= 1'b0;
    far2_q <= 1'b0;
    action_o <= 1'b0;
    repeat (width + 4) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// *** test_trigger_source_select.sv ***
// Purpose: self-checking bench for the trigger source block
// Assumes: master waits for waitrequest low, short internal period
// Notes:   read results checked from a queue of notes
`timescale 1ns/10ps
`default_nettype none
module test_trigger_source_select;
  import tss_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wreq, l0, l2, l2o, l2oe, l1, act, acq;
  logic [7:0]  lfsr = 8'h4C;
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          samples_checked = 0;
  int          acq_cnt = 0;
  int          base;
  int          exp_tab[6] = '{1, 1, 1, 0, 2, 2};

  tss_top #(.INT_PERIOD(20)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .line0_i(l0),
    .line2_i(l2), .line2_o(l2o), .line2_oe_o(l2oe), .line1_o(l1),
    .action_i(act), .acq_start_o(acq));
  tss_trig_src_model far (.clk_sys_i(clk_sys_i), .line2_o(l2o),
    .line2_oe_o(l2oe), .line0_o(l0), .line2_i_o(l2), .action_o(act));

  always #2.5 clk_sys_i = ~clk_sys_i;

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task automatic final_report();
    // a note never taken means a read result never came
    if (exp_q.size() != 0)
      num_errors++;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    do
      @(posedge clk_sys_i);
    while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic pulses(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      far.pulse(sel, int'(lfsr[1:0]) + 1);
    end
  endtask

  always @(posedge clk_sys_i)
    if (rd && wreq === 1'b0 && exp_q.size() > 0)
      check("readdata", rdata, exp_q.pop_front());

  // counted off the sampling edge to stay clear of the main sequence
  always @(negedge clk_sys_i)
    if (acq === 1'b1)
      acq_cnt++;

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rdchk(5'h00, 32'h0);
    rdchk(5'h01, 32'h0);
    rdchk(5'h02, 32'h1);
    rdchk(5'h06, 32'h0);
    bus(1'b1, 5'h04, 32'h5);
    pulses(0, 1);
    @(posedge clk_sys_i);
    base = acq_cnt;
    repeat (100) @(posedge clk_sys_i);
    check("internal_starts", acq_cnt - base, 5);
    rdchk(5'h03, 32'h0);
    for (int s = 0; s < 6; s++) begin
      // line 2 kept as input while it may trigger
      bus(1'b1, 5'h00, (32'(s) << 4) | 32'h1);
      bus(1'b1, 5'h04, 32'h5);
      // counted from here so a last internal start is not charged
      base = acq_cnt;
      pulses(0, 1);
      pulses(2, 1);
      if (s == 2)
        pulses(1, 1);
      repeat (10) @(posedge clk_sys_i);
      check("ext_starts", acq_cnt - base, exp_tab[s]);
    end
    rdchk(5'h03, 32'h7);
    bus(1'b1, 5'h00, 32'h71);
    rdchk(5'h00, 32'h51);
    bus(1'b1, 5'h01, 32'h111);
    bus(1'b1, 5'h02, 32'h3);
    rdchk(5'h01, 32'h110);
    bus(1'b1, 5'h00, 32'h31);
    base = acq_cnt;
    pulses(0, 7);
    repeat (10) @(posedge clk_sys_i);
    check("counter_starts", acq_cnt - base, 2);
    rdchk(5'h05, 32'h1);
    bus(1'b1, 5'h04, 32'h2);
    repeat (5) @(posedge clk_sys_i);
    check("counter_starts", acq_cnt - base, 2);
    rdchk(5'h05, 32'h0);
    bus(1'b1, 5'h01, 32'h10);
    pulses(0, 2);
    bus(1'b1, 5'h04, 32'h2);
    rdchk(5'h05, 32'h2);
    bus(1'b1, 5'h01, 32'h30);
    rdchk(5'h01, 32'h10);
    bus(1'b1, 5'h02, 32'h0);
    rdchk(5'h02, 32'h3);
    bus(1'b1, 5'h02, 32'h3FF);
    rdchk(5'h02, 32'h3FF);
    bus(1'b1, 5'h00, 32'h751);
    repeat (3) @(posedge clk_sys_i);
    check("line_outs", {29'h0, l2oe, l2o, l1}, 32'h7);
    bus(1'b1, 5'h00, 32'h51);
    repeat (3) @(posedge clk_sys_i);
    check("line_outs", {29'h0, l2oe, l2o, l1}, 32'h0);
    repeat (5) @(posedge clk_sys_i);
    final_report();
  end
endmodule
`default_nettype wire
